// ===== logic/defect_correction.sv
// defect pixel correction stage with ahb-lite registers
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
module defect_correction (
  input wire logic hclk, // bus and pixel clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // low in reset, then always ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic pix_in_valid, // sensor pixel present
  output logic pix_in_ready, // pixel taken
  input wire logic [7:0] pix_in_data, // sensor value
  input wire logic pix_in_sof, // first pixel of frame
  input wire logic pix_in_eol, // last pixel of line
  input wire logic pix_in_eof, // last pixel of frame
  output logic pix_out_valid, // corrected pixel present
  input wire logic pix_out_ready, // downstream takes it
  output logic [7:0] pix_out_data, // corrected value
  output logic pix_out_sof, // first pixel of frame
  output logic pix_out_eol, // last pixel of line
  output logic pix_out_eof // last pixel of frame
);
  localparam int FW = defect_pkg::PIX_W + defect_pkg::FLAG_W;

  table_if tbl ();

  logic fix_en_reg;
  logic [8:0] count_reg;
  logic [7:0] slot_reg;
  logic [11:0] col_reg;
  logic [11:0] row_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rd_word;
  logic [8:0] ptr_reg;
  logic [8:0] ptr_next;
  logic [15:0] fixed_cnt_reg;
  logic [11:0] col_pos_reg;
  logic [11:0] row_pos_reg;
  logic [11:0] pos_col;
  logic [11:0] pos_row;
  logic active;
  logic hit;
  logic behind;
  logic accept;
  logic push;
  logic right_v;
  logic cur_v_reg;
  logic [7:0] cur_data_reg;
  logic [2:0] cur_flags_reg;
  logic cur_fix_reg;
  logic left_v_reg;
  logic [7:0] left_reg;
  logic [7:0] fix_val;
  logic [7:0] push_data;
  logic fifo_ready;
  logic [3:0] fifo_level;
  logic [FW-1:0] fifo_out;

  defect_table u_table (
    .hclk(hclk),
    .hresetn(hresetn),
    .tbl(tbl.mem)
  );

  // bus slave: zero wait states, every answer okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_comb
  begin
    rd_word = 32'h00000000;
    if (haddr[7:0] == defect_pkg::A_ENABLE)
      rd_word = {31'h00000000, fix_en_reg};
    else if (haddr[7:0] == defect_pkg::A_COUNT)
      rd_word = {23'h000000, count_reg};
    else if (haddr[7:0] == defect_pkg::A_SLOT)
      rd_word = {24'h000000, slot_reg};
    else if (haddr[7:0] == defect_pkg::A_COLUMN)
      rd_word = {20'h00000, col_reg};
    else if (haddr[7:0] == defect_pkg::A_ROW)
      rd_word = {20'h00000, row_reg};
    else if (haddr[7:0] == defect_pkg::A_STATUS)
      rd_word = {fixed_cnt_reg, 7'h00, ptr_reg};
  end

  // read data is prepared in the address phase so no wait is needed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1])
        wr_addr_reg <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite)
        hrdata <= rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fix_en_reg <= defect_pkg::EN_RST;
      count_reg <= defect_pkg::COUNT_RST;
      slot_reg <= 8'h00;
      col_reg <= 12'h000;
      row_reg <= 12'h000;
    end
    else if (wr_pend_reg)
    begin
      if (wr_addr_reg == defect_pkg::A_ENABLE)
        fix_en_reg <= hwdata[0];
      else if (wr_addr_reg == defect_pkg::A_COUNT)
        count_reg <= (hwdata > 32'h00000100) ? defect_pkg::COUNT_MAX
                     : hwdata[8:0];
      else if (wr_addr_reg == defect_pkg::A_SLOT)
        slot_reg <= hwdata[7:0];
      else if (wr_addr_reg == defect_pkg::A_COLUMN)
        col_reg <= tbl.wr_col;
      else if (wr_addr_reg == defect_pkg::A_ROW)
        row_reg <= tbl.wr_row;
    end
  end

  // coordinates land in the table in the write's data phase
  assign tbl.we_col = wr_pend_reg && wr_addr_reg == defect_pkg::A_COLUMN;
  assign tbl.we_row = wr_pend_reg && wr_addr_reg == defect_pkg::A_ROW;
  assign tbl.wr_addr = slot_reg;
  assign tbl.wr_col = defect_pkg::clamp12(hwdata,
                                          defect_pkg::COL_LAST);
  assign tbl.wr_row = defect_pkg::clamp12(hwdata,
                                          defect_pkg::ROW_LAST);

  // pixel position and table walk
  assign accept = pix_in_valid && pix_in_ready;
  assign pos_col = pix_in_sof ? 12'h000 : col_pos_reg;
  assign pos_row = pix_in_sof ? 12'h000 : row_pos_reg;
  assign active = fix_en_reg && ptr_reg < count_reg;
  assign hit = active && tbl.rd_col == pos_col
               && tbl.rd_row == pos_row;
  // entries left behind by the scan are skipped one per pixel
  assign behind = active && {tbl.rd_row, tbl.rd_col} < {pos_row, pos_col};

  always_comb
  begin
    ptr_next = ptr_reg;
    if (accept && pix_in_eof)
      ptr_next = 9'h000;
    else if (accept && (hit || behind))
      ptr_next = ptr_reg + 9'h001;
  end

  // the read address runs one step ahead so the entry is ready in time
  assign tbl.rd_addr = ptr_next[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ptr_reg <= 9'h000;
    else
      ptr_reg <= ptr_next;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      col_pos_reg <= 12'h000;
      row_pos_reg <= 12'h000;
    end
    else if (accept)
    begin
      col_pos_reg <= pix_in_eol ? 12'h000 : pos_col + 12'h001;
      row_pos_reg <= pix_in_eol ? pos_row + 12'h001 : pos_row;
    end
  end

  // one pixel is held back so its right neighbour can be seen
  assign right_v = accept && !cur_flags_reg[1];
  assign push = cur_v_reg && fifo_ready && (accept || cur_flags_reg[1]);
  assign fix_val = defect_pkg::neighbour(left_v_reg, left_reg, right_v,
                                         pix_in_data, cur_data_reg);
  assign push_data = cur_fix_reg ? fix_val : cur_data_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cur_v_reg <= 1'b0;
      cur_data_reg <= 8'h00;
      cur_flags_reg <= 3'h0;
      cur_fix_reg <= 1'b0;
    end
    else if (accept)
    begin
      cur_v_reg <= 1'b1;
      cur_data_reg <= pix_in_data;
      cur_flags_reg <= {pix_in_eof, pix_in_eol, pix_in_sof};
      cur_fix_reg <= hit;
    end
    else if (push)
      cur_v_reg <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      left_v_reg <= 1'b0;
      left_reg <= 8'h00;
      fixed_cnt_reg <= 16'h0000;
    end
    else if (push)
    begin
      left_v_reg <= !cur_flags_reg[1];
      left_reg <= push_data;
      if (cur_fix_reg)
        fixed_cnt_reg <= fixed_cnt_reg + 16'h0001;
    end
  end

  // ready is registered, so it looks at a level one push stale
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pix_in_ready <= 1'b0;
    else
      pix_in_ready <= fifo_level <= defect_pkg::LEVEL_LIMIT
                      && !(accept && pix_in_eol)
                      && !(cur_v_reg && cur_flags_reg[1] && !push);
  end

  stream_fifo #(
    .W(FW),
    .DEPTH(defect_pkg::FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({cur_flags_reg, push_data}),
    .out_valid(pix_out_valid),
    .out_ready(pix_out_ready),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  assign pix_out_data = fifo_out[7:0];
  assign pix_out_sof = fifo_out[8];
  assign pix_out_eol = fifo_out[9];
  assign pix_out_eof = fifo_out[10];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_enable_reset: assert property (
    $rose(hreadyout) |-> fix_en_reg)
    else $error("enable not active after reset");
  chk_bypass_value: assert property (
    push && !cur_fix_reg |-> push_data == cur_data_reg)
    else $error("unlisted pixel was altered");
  chk_count_range: assert property (
    count_reg <= defect_pkg::COUNT_MAX)
    else $error("defect count above limit");
  chk_slot_write: assert property (
    wr_pend_reg && wr_addr_reg == defect_pkg::A_SLOT
    |=> slot_reg == $past(hwdata[7:0]))
    else $error("slot select not updated");
  chk_coord_range: assert property (
    col_reg <= defect_pkg::COL_LAST && row_reg <= defect_pkg::ROW_LAST)
    else $error("coordinate outside sensor");
  chk_fix_average: assert property (
    push && cur_fix_reg && left_v_reg && right_v
    |-> push_data == 8'((9'(left_reg) + 9'(pix_in_data)) >> 1))
    else $error("replacement is not neighbour mean");
  chk_table_load: assert property (
    wr_pend_reg && wr_addr_reg == defect_pkg::A_COLUMN && ptr_next == 9'h000
    && slot_reg == 8'h00 ##1 !tbl.we_col && ptr_next == 9'h000
    |=> tbl.rd_col == $past(col_reg, 1))
    else $error("written column not in table");
  chk_ptr_limit: assert property (
    ptr_reg >= count_reg |-> !hit)
    else $error("slot beyond count was applied");
  chk_ptr_step: assert property (
    accept && hit && !pix_in_eof |=> ptr_reg == $past(ptr_reg) + 9'h001)
    else $error("table walk did not advance");

  cov_fixed_pixel: cover property (push && cur_fix_reg);
  cov_line_flush: cover property (cur_v_reg && cur_flags_reg[1] ##1 push);
  cov_fifo_full: cover property (fifo_level == 4'h8);
  cov_frame_end: cover property (accept && pix_in_eof);
endmodule

// ===== logic/defect_pkg.sv
// constants, register map and helpers for the defect correction stage
// Overview of operation
// - enable switches replacement; resets active
// - defect count holds zero to 256
// - slot select 0-255 picks written entry
// - entries hold column and row within sensor
// - listed pixels replaced from neighbour values
// - written slot coordinates take effect immediately
package defect_pkg;
  localparam int PIX_W = 8;
  localparam int COL_W = 12;
  localparam int ROW_W = 12;
  localparam int SLOT_W = 8;
  localparam int CNT_W = 9;
  localparam int SLOTS = 256;
  localparam int FIFO_DEPTH = 8;
  localparam int FLAG_W = 3;
  localparam int sensor_width_max = 4096;
  localparam int sensor_height_max = 4096;
  localparam logic [COL_W-1:0] COL_LAST = COL_W'(sensor_width_max - 1);
  localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(sensor_height_max - 1);
  localparam logic [CNT_W-1:0] COUNT_MAX = 9'h100;
  // fifo must keep three free words when the input is granted
  localparam logic [3:0] LEVEL_LIMIT = 4'h5;
  localparam logic [7:0] A_ENABLE = 8'h00;
  localparam logic [7:0] A_COUNT = 8'h04;
  localparam logic [7:0] A_SLOT = 8'h08;
  localparam logic [7:0] A_COLUMN = 8'h0C;
  localparam logic [7:0] A_ROW = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic EN_RST = 1'b1;
  localparam logic [CNT_W-1:0] COUNT_RST = 9'h000;

  function automatic logic [COL_W-1:0] clamp12(input logic [31:0] v,
                                               input logic [11:0] lim);
    clamp12 = (v > {20'h00000, lim}) ? lim : v[11:0];
  endfunction

  function automatic logic [PIX_W-1:0] neighbour(input logic lv,
      input logic [PIX_W-1:0] l, input logic rv,
      input logic [PIX_W-1:0] r, input logic [PIX_W-1:0] own);
    logic [PIX_W:0] s;
    s = {1'b0, l} + {1'b0, r};
    if (lv && rv)
      neighbour = s[PIX_W:1];
    else if (lv)
      neighbour = l;
    else if (rv)
      neighbour = r;
    else
      neighbour = own;
  endfunction
endpackage

// ===== logic/defect_table.sv
// 256-entry coordinate memory with registered read data
`timescale 1ns/100ps
module defect_table (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  table_if.mem tbl // table port
);
  logic [11:0] col_mem [defect_pkg::SLOTS];
  logic [11:0] row_mem [defect_pkg::SLOTS];

  // fields written one at a time, as software sets them
  always_ff @(posedge hclk)
  begin
    if (tbl.we_col)
      col_mem[tbl.wr_addr] <= tbl.wr_col;
    if (tbl.we_row)
      row_mem[tbl.wr_addr] <= tbl.wr_row;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tbl.rd_col <= 12'h000;
      tbl.rd_row <= 12'h000;
    end
    else
    begin
      tbl.rd_col <= col_mem[tbl.rd_addr];
      tbl.rd_row <= row_mem[tbl.rd_addr];
    end
  end
endmodule

// ===== logic/stream_fifo.sv
// small fifo with registered head word
`timescale 1ns/100ps
module stream_fifo #(
  parameter int W = 11,
  parameter int DEPTH = 8
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // head valid
  input wire logic out_ready, // head taken
  output logic [W-1:0] out_data, // head word
  output logic [$clog2(DEPTH):0] level // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW-1:0] rd_ptr_next;
  logic [AW:0] level_next;
  logic push;
  logic pop;

  assign in_ready = level != (AW+1)'(DEPTH);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  assign level_next = level + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge hclk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      rd_ptr_reg <= rd_ptr_next;
      level <= level_next;
      out_valid <= level_next != '0;
      // a word written into the slot read next goes straight to the head
      if (push && wr_ptr_reg == rd_ptr_next)
        out_data <= in_data;
      else
        out_data <= mem[rd_ptr_next];
    end
  end
endmodule

// ===== logic/table_if.sv
// write and read port of the defect coordinate table
`timescale 1ns/100ps
interface table_if;
  logic we_col;
  logic we_row;
  logic [7:0] wr_addr;
  logic [11:0] wr_col;
  logic [11:0] wr_row;
  logic [7:0] rd_addr;
  logic [11:0] rd_col;
  logic [11:0] rd_row;
  modport ctrl (output we_col, we_row, wr_addr, wr_col, wr_row, rd_addr,
                input rd_col, rd_row);
  modport mem (input we_col, we_row, wr_addr, wr_col, wr_row, rd_addr,
               output rd_col, rd_row);
endinterface

// ===== tb/defect_correction_test.sv
// self-checking bench for the defect correction stage
`timescale 1ns/100ps
module defect_correction_test;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, flags;
  logic in_valid, in_ready, out_valid, out_ready;
  logic [7:0] in_data, out_data;
  logic sof, eol, eof, stall, slow, rd_phase;
  logic [31:0] pq[$], rq[$];
  logic [7:0] ta [6] = '{8'h04, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
  logic [31:0] tw [6] = '{32'h1FF, 32'h100, 32'h1FF, 32'hFFFF,
                          32'h1000, 32'h5};
  logic [31:0] te [6] = '{32'h100, 32'h100, 32'hFF, 32'hFFF,
                          32'hFFF, 32'h0};
  int num_errors = 0;
  int n_tests = 0;
  int seed = 31;
  int corr = 0;
  int dc [4];
  int dr [4];
  int i;

  defect_correction defect_correction_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pix_in_valid(in_valid), .pix_in_ready(in_ready),
    .pix_in_data(in_data), .pix_in_sof(flags[2]), .pix_in_eol(flags[1]),
    .pix_in_eof(flags[0]), .pix_out_valid(out_valid),
    .pix_out_ready(out_ready), .pix_out_data(out_data),
    .pix_out_sof(sof), .pix_out_eol(eol), .pix_out_eof(eof));

  pixel_partner pixel_partner_i (.hclk(hclk), .stall(stall), .slow(slow),
    .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .in_flags(flags), .out_ready(out_ready));

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge hclk);
    num_errors++;
    close_out;
  end

  // results are compared at the falling edge, where every flop has settled
  always @(negedge hclk)
  begin
    if (rd_phase && rq.size() > 0)
      check("hrdata", hrdata, rq.pop_front());
    if (out_valid === 1'b1 && out_ready)
      check("pixel", {21'h0, out_data, sof, eol, eof},
            pq.size() > 0 ? pq.pop_front() : 32'hFFFFFFFF);
  end

  task automatic wait_rdy;
    int k;
    logic r;
    k = 0;
    do
    begin
      @(negedge hclk);
      r = hreadyout;
      @(posedge hclk);
      k++;
    end
    while (r !== 1'b1 && k < 100);
    if (r !== 1'b1)
    begin
      num_errors++;
      close_out;
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    if (!wr)
      rq.push_back(d);
    rd_phase = !wr;
    wait_rdy;
    rd_phase = 1'b0;
  endtask

  task automatic entry(input int s, input int c, input int r);
    dc[s] = c;
    dr[s] = r;
    bus(1'b1, defect_pkg::A_SLOT, 32'(s));
    bus(1'b1, defect_pkg::A_COLUMN, 32'(c));
    bus(1'b1, defect_pkg::A_ROW, 32'(r));
  endtask

  task automatic frame(input int w, input int h, input int n,
                       input bit en);
    int x, y, p, s, k;
    logic [7:0] o [0:63];
    bit hit;
    for (p = 0; p < w * h; p++)
    begin
      x = p % w;
      y = p / w;
      hit = 0;
      for (k = 0; k < n; k++)
        if (dc[k] == x && dr[k] == y)
          hit = en;
      o[p] = pixel_partner_i.img[p];
      if (hit && w > 1)
      begin
        corr++;
        if (x == 0)
          o[p] = pixel_partner_i.img[p + 1];
        else if (x == w - 1)
          o[p] = o[p - 1];
        else
        begin
          s = o[p - 1] + pixel_partner_i.img[p + 1];
          o[p] = s[8:1];
        end
      end
      pq.push_back({21'h0, o[p], p == 0, x == w - 1, p == w * h - 1});
    end
    pixel_partner_i.send_frame(w, h);
  endtask

  task automatic drain(input string name);
    int k;
    k = 0;
    while (pq.size() > 0 && k < 2000)
    begin
      @(posedge hclk);
      k++;
    end
    check("pixels left", pq.size(), 0);
    repeat (4) @(posedge hclk);
    $display("test %s done", name);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    stall = 1'b0;
    slow = 1'b0;
    rd_phase = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (i = 0; i < 7; i++)
      bus(1'b0, defect_pkg::A_ENABLE + 8'(4 * i),
          i == 0 ? 32'(defect_pkg::EN_RST) : 32'h0);
    $display("test reset values done");
    for (i = 0; i < 6; i++)
    begin
      bus(1'b1, ta[i], tw[i]);
      bus(1'b0, ta[i], te[i]);
    end
    $display("test register limits done");
    for (i = 0; i < 64; i++)
      pixel_partner_i.img[i] = 8'($random(seed));
    // slots go in raster order; the last one stays above the count first
    entry(0, 0, 0);
    entry(1, 3, 1);
    entry(2, 5, 1);
    entry(3, 2, 3);
    bus(1'b1, defect_pkg::A_COUNT, 32'h3);
    slow = 1'b1;
    frame(6, 4, 3, 1'b1);
    drain("count limit");
    bus(1'b1, defect_pkg::A_COUNT, 32'h4);
    stall = 1'b1;
    fork
      frame(6, 4, 4, 1'b1);
      begin
        repeat (40) @(negedge hclk);
        check("in_ready", {31'h0, in_ready}, 32'h0);
        stall = 1'b0;
      end
    join
    drain("fifo full");
    bus(1'b1, defect_pkg::A_ENABLE, 32'h0);
    bus(1'b0, defect_pkg::A_ENABLE, 32'h0);
    frame(6, 4, 4, 1'b0);
    drain("pass through");
    bus(1'b0, defect_pkg::A_STATUS, {16'(corr), 16'h0});
    check("source hangs", pixel_partner_i.hangs, 0);
    repeat (2) @(posedge hclk);
    close_out;
  end
endmodule

// ===== tb/pixel_partner.sv
// sensor source and downstream sink around the correction stage
`timescale 1ns/100ps
module pixel_partner (
  input wire logic hclk, // clock
  input wire logic stall, // hold downstream ready low
  input wire logic slow, // insert random gaps in the source
  output logic in_valid, // pixel offered
  input wire logic in_ready, // pixel taken
  output logic [7:0] in_data, // sensor value
  output logic [2:0] in_flags, // sof, eol, eof
  output logic out_ready // downstream accepts
);
  logic [7:0] img [0:63];
  int seed = 31;
  int hangs = 0;

  initial
  begin
    in_valid = 1'b0;
    in_data = 8'h00;
    in_flags = 3'h0;
    out_ready = 1'b0;
  end

  // a real pipeline stalls at random, so ready is never trusted to stay up
  always @(posedge hclk)
    out_ready <= !stall && ($random(seed) % 4 != 0);

  task automatic send_frame(input int w, input int h);
    int p;
    int k;
    logic r;
    for (p = 0; p < w * h; p++)
    begin
      if (slow && $random(seed) % 3 == 0)
      begin
        in_valid <= 1'b0;
        // idle data is inverted so a stale value never looks valid
        in_data <= ~in_data;
        @(posedge hclk);
      end
      in_valid <= 1'b1;
      in_data <= img[p];
      in_flags <= {p == 0, p % w == w - 1, p == w * h - 1};
      k = 0;
      do
      begin
        @(negedge hclk);
        r = in_ready;
        @(posedge hclk);
        k++;
      end
      while (r !== 1'b1 && k < 1000);
      if (r !== 1'b1)
        hangs++;
    end
    in_valid <= 1'b0;
    in_data <= ~in_data;
    @(posedge hclk);
  endtask
endmodule
